// ===== core/seq_defs.vh
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Register port addresses
`define ADDR_W         7
`define ADDR_STACK_TOP 7'h1F
`define ADDR_CONFIG    7'h20
`define ADDR_CHANNEL   7'h21
`define ADDR_STATUS    7'h22
`define ADDR_RESULT    7'h23

// Configuration register fields
`define CFG_SEQ_EN     0
`define CFG_BURST      1
`define CFG_CRC_EN     2
`define CFG_STATUS_EN  3
`define CFG_OSR_LO     4
`define CFG_OSR_HI     6
`define CFG_W          7
`define CFG_RESET      7'h00

// Stack step fields: A select, B select, last-step marker
`define STEP_A_LO      0
`define STEP_A_HI      3
`define STEP_B_LO      4
`define STEP_B_HI      7
`define STEP_LAST      8
`define STEP_W         9
`define STEP_RESET     9'h000
`define CHAN_RESET     8'h00

// Channel identifiers beyond the eight inputs
`define CH_SUPPLY      4'h8
`define CH_REGULATOR   4'h9
`define CH_SELFTEST    4'hA
`define SELFTEST_A     16'hAAAA
`define SELFTEST_B     16'h5555
`define CRC_SEED       8'h00

// Synchronised pin vector positions
`define PIN_TRIG       9
`define PIN_PART       8
`define PIN_SW         7
`define PIN_SEQ        6
`define PIN_BURST      5
`define PIN_CRC        4
`define PIN_SERIAL     3
`define PIN_CHSEL_HI   2
`define PIN_W          10

// Straps are caught on the third edge after release, while the counter holds this value
`define STRAP_CNT      2'h2
`define STRAP_DONE     2'h3

`endif

// ===== core/adc_channel_sequencer_burst_crc.v
`timescale 1ns/1ps
`include "seq_defs.vh"

module adc_channel_sequencer_burst_crc #(
    parameter STEPS = 32,
    parameter PTR_W = 5,
    parameter SEL_W = 4,
    parameter OSR_W = 3,
    parameter DATA_W = 16
) (
    // Clock and resets
    input  wire              CORE_CLK,
    input  wire              RESET,
    input  wire              PARTIAL_RESET,
    // Host pins
    input  wire              CONVERSION_TRIGGER,
    input  wire              SOFTWARE_MODE,
    input  wire              SEQUENCE_ENABLE_CTL,
    input  wire              BURST_ENABLE,
    input  wire              CHECKSUM_ENABLE,
    input  wire              SERIAL_INTERFACE,
    input  wire [2:0]        CHANNEL_PAIR_SELECT_PINS,
    output reg               BUSY,
    // Register port
    input  wire [6:0]        REG_ADDR,
    input  wire [15:0]       REG_WDATA,
    input  wire              REG_WR,
    input  wire              REG_RD,
    output reg  [15:0]       REG_RDATA,
    // Converter core
    output reg  [SEL_W-1:0]  A_SIDE_MUX_SELECT,
    output reg  [SEL_W-1:0]  B_SIDE_MUX_SELECT,
    output reg               CONV_START,
    input  wire              CONV_DONE,
    input  wire [DATA_W-1:0] CONV_DATA_A,
    input  wire [DATA_W-1:0] CONV_DATA_B
);

    localparam S_IDLE  = 4'b0001;
    localparam S_ISSUE = 4'b0010;
    localparam S_WAIT  = 4'b0100;
    localparam S_STORE = 4'b1000;
    localparam SUM_W   = DATA_W + (1 << OSR_W) - 1;

    reg [`PIN_W-1:0]      pin_meta;
    reg [`PIN_W-1:0]      pin_sync;
    reg                   trig_d;
    reg                   part_d;
    reg [1:0]             strap_cnt;
    reg                   sw_mode;
    reg                   hw_seq;
    reg                   hw_burst;
    reg                   hw_crc;
    reg [2:0]             hw_count;
    reg [2:0]             hw_pair;
    reg [2:0]             chsel_snap;
    reg                   chsel_stable;
    reg [`STEP_W-1:0]     stack [0:STEPS-1];
    reg [`CFG_W-1:0]      cfg;
    reg [7:0]             chan;
    reg [3:0]             state;
    reg [PTR_W-1:0]       ptr;
    reg [PTR_W:0]         pair_idx;
    reg [PTR_W:0]         pairs;
    reg [PTR_W+1:0]       rd_idx;
    reg [7:0]             osr_cnt;
    reg [SUM_W-1:0]       sum_a;
    reg [SUM_W-1:0]       sum_b;
    reg [7:0]             crc;
    reg [DATA_W-1:0]      res_mem [0:2*STEPS-1];
    integer               i;

    wire trig_rise = pin_sync[`PIN_TRIG] & ~trig_d;
    wire part_rise = pin_sync[`PIN_PART] & ~part_d;
    wire [2:0] chsel = pin_sync[`PIN_CHSEL_HI:0];

    wire seq_on   = sw_mode ? cfg[`CFG_SEQ_EN] : hw_seq;
    wire burst_on = seq_on & (sw_mode ? cfg[`CFG_BURST] : hw_burst);
    wire crc_on   = sw_mode ? (cfg[`CFG_CRC_EN] | cfg[`CFG_STATUS_EN]) : hw_crc;
    wire [OSR_W-1:0] oversampling_ratio = sw_mode ? cfg[`CFG_OSR_HI:`CFG_OSR_LO] : {OSR_W{1'b0}};
    wire [7:0] osr_last = (8'h01 << oversampling_ratio) - 8'h01;

    // Current step's selectors
    wire [`STEP_W-1:0] step = stack[ptr];
    reg  [SEL_W-1:0]   sel_a;
    reg  [SEL_W-1:0]   sel_b;
    reg                last_step;
    always @* begin
        if (seq_on && sw_mode) begin
            sel_a = step[`STEP_A_HI:`STEP_A_LO];
            sel_b = step[`STEP_B_HI:`STEP_B_LO];
            last_step = step[`STEP_LAST] || (ptr == STEPS - 1);
        end else if (seq_on) begin
            sel_a = {1'b0, ptr[2:0]};
            sel_b = {1'b0, ptr[2:0]};
            last_step = (ptr[2:0] >= hw_count);
        end else if (sw_mode) begin
            sel_a = chan[3:0];
            sel_b = chan[7:4];
            last_step = 1'b1;
        end else begin
            sel_a = {1'b0, hw_pair};
            sel_b = {1'b0, hw_pair};
            last_step = 1'b1;
        end
    end

    // Averaged results with the self-test override
    wire [SUM_W-1:0] avg_a = sum_a >> oversampling_ratio;
    wire [SUM_W-1:0] avg_b = sum_b >> oversampling_ratio;
    wire selftest = sw_mode && (A_SIDE_MUX_SELECT == `CH_SELFTEST ||
                                B_SIDE_MUX_SELECT == `CH_SELFTEST);
    wire [DATA_W-1:0] res_a = selftest ? `SELFTEST_A : avg_a[DATA_W-1:0];
    wire [DATA_W-1:0] res_b = selftest ? `SELFTEST_B : avg_b[DATA_W-1:0];

    function [7:0] crc_fold;
        input [15:0] d;
        input [7:0]  c;
        begin
            crc_fold[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
            crc_fold[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[1]^d[0]
                          ^c[1]^c[4]^c[5]^c[6]^c[7];
            crc_fold[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]
                          ^c[0]^c[2]^c[4]^c[5]^c[7];
            crc_fold[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]
                          ^c[1]^c[3]^c[5]^c[6];
            crc_fold[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]
                          ^c[0]^c[2]^c[4]^c[6]^c[7];
            crc_fold[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]
                          ^c[1]^c[3]^c[5]^c[7];
            crc_fold[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
            crc_fold[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[5]^c[7];
        end
    endfunction

    wire [7:0] crc_mid  = crc_fold(res_a, crc);
    wire [7:0] next_crc = crc_fold(res_b, crc_mid);
    wire last_sample = (osr_cnt == osr_last);
    wire [PTR_W+1:0] total_words = {pairs, 1'b0};
    wire [15:0] status_word = {3'h0, ptr, crc};

    // Result store has no reset, so it sits in its own process
    always @(posedge CORE_CLK) begin
        if (state == S_STORE && last_sample) begin
            res_mem[{pair_idx[PTR_W-1:0], 1'b0}] <= res_a;
            res_mem[{pair_idx[PTR_W-1:0], 1'b1}] <= res_b;
        end
    end

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            pin_meta <= {`PIN_W{1'b0}};
            pin_sync <= {`PIN_W{1'b0}};
            trig_d <= 1'b0;
            part_d <= 1'b0;
            strap_cnt <= 2'h0;
            sw_mode <= 1'b0;
            hw_seq <= 1'b0;
            hw_burst <= 1'b0;
            hw_crc <= 1'b0;
            hw_count <= 3'h0;
            hw_pair <= 3'h0;
            chsel_snap <= 3'h0;
            chsel_stable <= 1'b0;
            for (i = 0; i < STEPS; i = i + 1) begin
                stack[i] <= `STEP_RESET;
            end
            cfg <= `CFG_RESET;
            chan <= `CHAN_RESET;
            state <= S_IDLE;
            ptr <= {PTR_W{1'b0}};
            pair_idx <= {(PTR_W+1){1'b0}};
            pairs <= {(PTR_W+1){1'b0}};
            rd_idx <= {(PTR_W+2){1'b0}};
            osr_cnt <= 8'h00;
            sum_a <= {SUM_W{1'b0}};
            sum_b <= {SUM_W{1'b0}};
            crc <= `CRC_SEED;
            BUSY <= 1'b0;
            REG_RDATA <= 16'h0000;
            A_SIDE_MUX_SELECT <= {SEL_W{1'b0}};
            B_SIDE_MUX_SELECT <= {SEL_W{1'b0}};
            CONV_START <= 1'b0;
        end else begin
            pin_meta <= {CONVERSION_TRIGGER, PARTIAL_RESET, SOFTWARE_MODE,
                         SEQUENCE_ENABLE_CTL, BURST_ENABLE, CHECKSUM_ENABLE,
                         SERIAL_INTERFACE, CHANNEL_PAIR_SELECT_PINS};
            pin_sync <= pin_meta;
            trig_d <= pin_sync[`PIN_TRIG];
            part_d <= pin_sync[`PIN_PART];
            CONV_START <= 1'b0;
            REG_RDATA <= 16'h0000;

            // Straps caught once synchronised values are valid
            if (strap_cnt != `STRAP_DONE) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
            if (strap_cnt == `STRAP_CNT) begin
                sw_mode <= pin_sync[`PIN_SW];
                hw_seq <= pin_sync[`PIN_SEQ];
                hw_burst <= pin_sync[`PIN_SEQ] & pin_sync[`PIN_BURST];
                hw_crc <= pin_sync[`PIN_CRC] & pin_sync[`PIN_SERIAL];
                hw_count <= chsel;
                hw_pair <= chsel;
            end

            // Register writes; config held even across partial reset
            if (REG_WR && sw_mode) begin
                if (REG_ADDR <= `ADDR_STACK_TOP) begin
                    stack[REG_ADDR[PTR_W-1:0]] <= REG_WDATA[`STEP_W-1:0];
                end else if (REG_ADDR == `ADDR_CONFIG) begin
                    cfg <= REG_WDATA[`CFG_W-1:0];
                end else if (REG_ADDR == `ADDR_CHANNEL) begin
                    chan <= REG_WDATA[7:0];
                end
            end

            // Register reads, answered in the next cycle only
            if (REG_RD) begin
                if (REG_ADDR <= `ADDR_STACK_TOP) begin
                    REG_RDATA <= {7'h00, stack[REG_ADDR[PTR_W-1:0]]};
                end else if (REG_ADDR == `ADDR_CONFIG) begin
                    REG_RDATA <= {9'h000, cfg};
                end else if (REG_ADDR == `ADDR_CHANNEL) begin
                    REG_RDATA <= {8'h00, chan};
                end else if (REG_ADDR == `ADDR_STATUS) begin
                    REG_RDATA <= crc_on ? status_word : 16'h0000;
                end else if (REG_ADDR == `ADDR_RESULT && !BUSY) begin
                    if (rd_idx < total_words) begin
                        REG_RDATA <= res_mem[rd_idx[PTR_W:0]];
                        rd_idx <= rd_idx + 1'b1;
                    end else if (crc_on && rd_idx == total_words) begin
                        REG_RDATA <= status_word;
                        rd_idx <= rd_idx + 1'b1;
                    end
                end
            end

            if (part_rise) begin
                // Abandons any conversion in flight
                ptr <= {PTR_W{1'b0}};
                state <= S_IDLE;
                BUSY <= 1'b0;
                hw_count <= chsel;
                hw_pair <= chsel;
            end else begin
                if (BUSY && chsel != chsel_snap) begin
                    chsel_stable <= 1'b0;
                end
                case (state)
                    S_IDLE: begin
                        if (trig_rise && strap_cnt == `STRAP_DONE) begin
                            BUSY <= 1'b1;
                            pair_idx <= {(PTR_W+1){1'b0}};
                            rd_idx <= {(PTR_W+2){1'b0}};
                            crc <= `CRC_SEED;
                            chsel_snap <= chsel;
                            chsel_stable <= 1'b1;
                            state <= S_ISSUE;
                        end
                    end
                    S_ISSUE: begin
                        A_SIDE_MUX_SELECT <= sel_a;
                        B_SIDE_MUX_SELECT <= sel_b;
                        if (osr_cnt == 8'h00) begin
                            sum_a <= {SUM_W{1'b0}};
                            sum_b <= {SUM_W{1'b0}};
                        end
                        CONV_START <= 1'b1;
                        state <= S_WAIT;
                    end
                    S_WAIT: begin
                        if (CONV_DONE) begin
                            sum_a <= sum_a + {{(SUM_W-DATA_W){1'b0}}, CONV_DATA_A};
                            sum_b <= sum_b + {{(SUM_W-DATA_W){1'b0}}, CONV_DATA_B};
                            state <= S_STORE;
                        end
                    end
                    S_STORE: begin
                        if (!last_sample) begin
                            osr_cnt <= osr_cnt + 8'h01;
                            state <= S_ISSUE;
                        end else begin
                            osr_cnt <= 8'h00;
                            crc <= next_crc;
                            pair_idx <= pair_idx + 1'b1;
                            if (!seq_on) begin
                                // Pair for the next trigger sampled while busy
                                hw_pair <= chsel;
                            end else if (last_step) begin
                                ptr <= {PTR_W{1'b0}};
                            end else begin
                                ptr <= ptr + 1'b1;
                            end
                            if (burst_on && seq_on && !last_step) begin
                                state <= S_ISSUE;
                            end else begin
                                BUSY <= 1'b0;
                                pairs <= pair_idx + 1'b1;
                                state <= S_IDLE;
                                if (seq_on && last_step && chsel_stable &&
                                    chsel == chsel_snap) begin
                                    hw_count <= chsel_snap;
                                end
                            end
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // adc_channel_sequencer_burst_crc

// ===== tb/seq_checker.sv
`timescale 1ns/1ps
`include "seq_defs.vh"
module seq_checker #(
    parameter SEL_W = 4
) (
    input wire             CORE_CLK,
    input wire             RESET,
    input wire             CONVERSION_TRIGGER,
    input wire             BUSY,
    input wire [6:0]       REG_ADDR,
    input wire             REG_RD,
    input wire [15:0]      REG_RDATA,
    input wire [SEL_W-1:0] A_SIDE_MUX_SELECT,
    input wire             CONV_START,
    input wire             CONV_DONE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    sequence step_launch;
        ##1 CONV_START ##1 !CONV_START;
    endsequence
    sequence result_read_busy;
        REG_RD && REG_ADDR == `ADDR_RESULT && BUSY;
    endsequence
    chk_busy_launch: assert property ($rose(BUSY) |-> step_launch)
        else $error("no single start pulse after busy rise");
    chk_start_in_busy: assert property (CONV_START |-> BUSY)
        else $error("start pulse outside busy");
    chk_busy_after_done: assert property (CONV_DONE |=> BUSY)
        else $error("busy dropped before the result was stored");
    chk_busy_end_done: assert property ($fell(BUSY) |-> $past(CONV_DONE, 2))
        else $error("busy fell without a finished conversion");
    chk_busy_from_trig: assert property ($rose(BUSY) |-> $past(CONVERSION_TRIGGER, 3))
        else $error("busy rose without a trigger");
    chk_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
        else $error("read data outside the answer cycle");
    chk_busy_result_zero: assert property (result_read_busy |=> REG_RDATA == 16'h0000)
        else $error("result readable while busy");
    chk_sel_with_start: assert property ($changed(A_SIDE_MUX_SELECT) && BUSY |-> CONV_START)
        else $error("selector moved in mid conversion");
endmodule // seq_checker
bind adc_channel_sequencer_burst_crc seq_checker #(.SEL_W(SEL_W)) chk_i (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .CONVERSION_TRIGGER(CONVERSION_TRIGGER),
    .BUSY(BUSY), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .A_SIDE_MUX_SELECT(A_SIDE_MUX_SELECT), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE)
);

// ===== tb/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
    input  wire        clk,
    input  wire        rst,
    input  wire        slow,
    input  wire        start,
    input  wire [3:0]  a_sel,
    input  wire [3:0]  b_sel,
    output reg         done,
    output wire [15:0] data_a,
    output wire [15:0] data_b
);
    reg       run;
    reg [3:0] cnt;
    reg [3:0] la;
    reg [3:0] lb;
    // Outside the done cycle the lines carry junk, so a late sample shows
    assign data_a = done ? {12'h123, la} : ~{12'h123, la};
    assign data_b = done ? {12'h456, lb} : ~{12'h456, lb};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            run <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                run <= 1'b1;
                cnt <= slow ? 4'h9 : 4'h1;
                la <= a_sel;
                lb <= b_sel;
            end else if (run && cnt == 4'h0) begin
                run <= 1'b0;
                done <= 1'b1;
            end else if (run)
                cnt <= cnt - 4'h1;
        end
    end
endmodule // conv_core_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "seq_defs.vh"
module testbench;
    reg         CORE_CLK = 1'b0;
    reg         RESET = 1'b1;
    reg         PARTIAL_RESET = 1'b0;
    reg         CONVERSION_TRIGGER = 1'b0;
    reg         SOFTWARE_MODE = 1'b1;
    reg         SEQUENCE_ENABLE_CTL = 1'b0;
    reg         BURST_ENABLE = 1'b0;
    reg         CHECKSUM_ENABLE = 1'b0;
    reg         SERIAL_INTERFACE = 1'b0;
    reg  [2:0]  CHANNEL_PAIR_SELECT_PINS = 3'h0;
    reg  [6:0]  REG_ADDR = 7'h00;
    reg  [15:0] REG_WDATA = 16'h0000;
    reg         REG_WR = 1'b0;
    reg         REG_RD = 1'b0;
    reg         slow = 1'b0;
    wire        BUSY, CONV_START, CONV_DONE;
    wire [15:0] REG_RDATA, CONV_DATA_A, CONV_DATA_B;
    wire [3:0]  A_SIDE_MUX_SELECT, B_SIDE_MUX_SELECT;
    reg  [15:0] done_count = 16'h0000;
    reg  [15:0] d0;
    reg  [3:0]  sa [0:31];
    reg  [3:0]  sb [0:31];
    integer     bad_count = 0;
    integer     num_checks = 0;
    integer     len, n, j;
    always #25 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) if (CONV_DONE === 1'b1) done_count <= done_count + 16'h0001;
    adc_channel_sequencer_burst_crc uut (.CORE_CLK(CORE_CLK), .RESET(RESET),
        .PARTIAL_RESET(PARTIAL_RESET), .CONVERSION_TRIGGER(CONVERSION_TRIGGER),
        .SOFTWARE_MODE(SOFTWARE_MODE), .SEQUENCE_ENABLE_CTL(SEQUENCE_ENABLE_CTL),
        .BURST_ENABLE(BURST_ENABLE), .CHECKSUM_ENABLE(CHECKSUM_ENABLE),
        .SERIAL_INTERFACE(SERIAL_INTERFACE), .CHANNEL_PAIR_SELECT_PINS(CHANNEL_PAIR_SELECT_PINS),
        .BUSY(BUSY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .A_SIDE_MUX_SELECT(A_SIDE_MUX_SELECT),
        .B_SIDE_MUX_SELECT(B_SIDE_MUX_SELECT), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
        .CONV_DATA_A(CONV_DATA_A), .CONV_DATA_B(CONV_DATA_B));
    conv_core_model core (.clk(CORE_CLK), .rst(RESET), .slow(slow), .start(CONV_START),
        .a_sel(A_SIDE_MUX_SELECT), .b_sel(B_SIDE_MUX_SELECT), .done(CONV_DONE),
        .data_a(CONV_DATA_A), .data_b(CONV_DATA_B));
    function [15:0] exp_a(input [3:0] a, input [3:0] b);
        exp_a = (a == `CH_SELFTEST || b == `CH_SELFTEST) ? `SELFTEST_A : {12'h123, a};
    endfunction
    function [15:0] exp_b(input [3:0] a, input [3:0] b);
        exp_b = (a == `CH_SELFTEST || b == `CH_SELFTEST) ? `SELFTEST_B : {12'h456, b};
    endfunction
    // Repeated terms already cancelled
    function [7:0] fold(input [15:0] d, input [7:0] c);
        begin
            fold[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
            fold[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
            fold[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
            fold[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
            fold[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
            fold[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]^c[1]^c[3]^c[5]^c[7];
            fold[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
            fold[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[5]^c[7];
        end
    endfunction
    task check(input [15:0] seen, input [15:0] exp_v);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp_v) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp_v);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (bad_count == 0 && num_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task full_reset;
        begin
            RESET <= 1'b1;
            repeat (4) @(posedge CORE_CLK);
            RESET <= 1'b0;
            repeat (6) @(posedge CORE_CLK);
        end
    endtask
    task wr(input [6:0] a, input [15:0] d);
        begin
            @(posedge CORE_CLK);
            REG_ADDR <= a;
            REG_WDATA <= d;
            REG_WR <= 1'b1;
            @(posedge CORE_CLK);
            REG_WR <= 1'b0;
        end
    endtask
    task rd(input [6:0] a, input [15:0] exp_v);
        begin
            @(posedge CORE_CLK);
            REG_ADDR <= a;
            REG_RD <= 1'b1;
            @(posedge CORE_CLK);
            REG_RD <= 1'b0;
            @(negedge CORE_CLK);
            check(REG_RDATA, exp_v);
        end
    endtask
    // Alternates prompt and slow converter answers
    task trig;
        integer i;
        begin
            @(posedge CORE_CLK);
            slow <= ~slow;
            CONVERSION_TRIGGER <= 1'b1;
            repeat (4) @(posedge CORE_CLK);
            rd(`ADDR_RESULT, 16'h0000);
            @(posedge CORE_CLK);
            CONVERSION_TRIGGER <= 1'b0;
            i = 0;
            // Busy is looked at away from the edge that moves it
            while (BUSY !== 1'b0 && i < 2000) begin
                @(negedge CORE_CLK);
                i = i + 1;
            end
            if (i == 2000) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: busy never fell", $time);
                tally_and_finish;
            end
        end
    endtask
    task drain(input integer base, input integer cnt, input st, input [4:0] ptr);
        integer k;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (k = base; k < base + cnt; k = k + 1) begin
                rd(`ADDR_RESULT, exp_a(sa[k], sb[k]));
                c = fold(exp_a(sa[k], sb[k]), c);
                rd(`ADDR_RESULT, exp_b(sa[k], sb[k]));
                c = fold(exp_b(sa[k], sb[k]), c);
            end
            if (st) begin
                rd(`ADDR_RESULT, {3'b000, ptr, c});
                rd(`ADDR_STATUS, {3'b000, ptr, c});
            end
            rd(`ADDR_RESULT, 16'h0000);
        end
    endtask
    initial begin
        j = $urandom(32'hab94_0ba0);
        full_reset;
        rd(`ADDR_CONFIG, 16'h0000);
        rd(7'h7F, 16'h0000);
        len = 2 + $urandom % 4;
        // A second marker further up must lose to the first one
        for (j = 0; j < 32; j = j + 1) begin
            sa[j] = (j == 1) ? `CH_SUPPLY : 4'($urandom % 10);
            sb[j] = (j == 0) ? `CH_REGULATOR : 4'($urandom % 10);
            wr(j[6:0], {7'h00, j == len - 1 || j == len + 2, sb[j], sa[j]});
        end
        rd(7'(len - 1), {7'h00, 1'b1, sb[len-1], sa[len-1]});
        wr(`ADDR_CONFIG, 16'h0017);
        trig;
        d0 = done_count;
        trig;
        check(done_count - d0, 16'(2 * len));
        drain(0, len, 1'b1, 5'h00);
        wr(`ADDR_CONFIG, 16'h0009);
        for (j = 0; j <= len; j = j + 1) begin
            trig;
            drain(j % len, 1, 1'b1, 5'((j + 1) % len));
        end
        trig;
        @(posedge CORE_CLK);
        PARTIAL_RESET <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        PARTIAL_RESET <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        rd(`ADDR_CONFIG, 16'h0009);
        trig;
        drain(0, 1, 1'b1, 5'h01);
        sa[0] = `CH_SELFTEST;
        sb[0] = 4'h3;
        wr(`ADDR_CHANNEL, 16'h003A);
        wr(`ADDR_CONFIG, 16'h0002);
        d0 = done_count;
        trig;
        check(done_count - d0, 16'h0001);
        drain(0, 1, 1'b0, 5'h00);
        rd(`ADDR_STATUS, 16'h0000);
        @(posedge CORE_CLK);
        SOFTWARE_MODE <= 1'b0;
        SEQUENCE_ENABLE_CTL <= 1'b1;
        BURST_ENABLE <= 1'b1;
        CHECKSUM_ENABLE <= 1'b1;
        SERIAL_INTERFACE <= 1'($urandom % 2);
        n = $urandom % 8;
        CHANNEL_PAIR_SELECT_PINS <= 3'(n);
        for (j = 0; j < 8; j = j + 1) begin
            sa[j] = j[3:0];
            sb[j] = j[3:0];
        end
        full_reset;
        trig;
        drain(0, n + 1, SERIAL_INTERFACE, 5'h00);
        n = $urandom % 8;
        @(posedge CORE_CLK);
        CHANNEL_PAIR_SELECT_PINS <= 3'(n);
        trig;
        trig;
        drain(0, n + 1, SERIAL_INTERFACE, 5'h00);
        // Hardware sequencer without burst: one pair per trigger
        @(posedge CORE_CLK);
        BURST_ENABLE <= 1'b0;
        full_reset;
        for (j = 0; j <= n + 1; j = j + 1) begin
            trig;
            drain(j % (n + 1), 1, SERIAL_INTERFACE, 5'((j + 1) % (n + 1)));
        end
        // Sequencer strap low: the select pins pick one pair
        @(posedge CORE_CLK);
        SEQUENCE_ENABLE_CTL <= 1'b0;
        full_reset;
        trig;
        drain(n, 1, SERIAL_INTERFACE, 5'h00);
        tally_and_finish;
    end
endmodule // testbench
